// ==== sctc_params.svh ====
/*
  Offsets, field positions, reset values and timing counts of the serial
  transmit start-up and card clock block.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
`ifndef SCTC_PARAMS_SVH
`define SCTC_PARAMS_SVH

`define SCTC_OFS_MODE 12'h000
`define SCTC_OFS_CTRL 12'h004
`define SCTC_OFS_RATE 12'h008
`define SCTC_OFS_SCMODE 12'h00C
`define SCTC_OFS_TDATA 12'h010
`define SCTC_OFS_STAT 12'h014

`define SCTC_POS_GSM 7
`define SCTC_POS_CHR7 6
`define SCTC_POS_PAREN 5
`define SCTC_POS_PARODD 4
`define SCTC_POS_STOP2 3
`define SCTC_POS_TXEN 5
`define SCTC_POS_RXEN 4
`define SCTC_POS_CKE 0
`define SCTC_POS_SCEN 0
`define SCTC_POS_INV 2
`define SCTC_POS_TDE 0
`define SCTC_POS_TEND 1
`define SCTC_POS_STATE 2
`define SCTC_POS_LINE 4

`define SCTC_RST_RATE 8'h03
`define SCTC_RST_BYTE 8'h00
`define SCTC_BASE_PER_BIT 16

`endif

// ==== sctc_pkg.sv ====
/*
  Types of the serial transmit start-up and card clock block.
  Assumes sctc_params.svh for all numeric constants.
*/
package sctc_pkg;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_IDLE = 2'b10,
    ST_SHIFT = 2'b11
  } sctc_state_t;

  typedef struct packed {
    logic [1:0] cke;
    logic rxEn;
    logic txEn;
  } sctc_ctrl_t;

  typedef struct packed {
    logic gsmFlag;
    logic chr7;
    logic parEn;
    logic parOdd;
    logic stop2;
  } sctc_mode_t;

  typedef struct packed {
    logic inv;
    logic scEn;
  } sctc_scm_t;

endpackage : sctc_pkg

// ==== sctc_base_clk.sv ====
/*
  Base clock and bit tick generator.
  Assumes one clock domain; halfDiv comes from a register on the same clock.
*/
`timescale 1ns/100ps
`include "sctc_params.svh"

module sctc_base_clk #(
  parameter int BASE_PER_BIT = `SCTC_BASE_PER_BIT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [7:0] halfDiv,
  output logic baseClk,
  output logic baseEdge,
  output logic bitTick
);

  if (BASE_PER_BIT < 1 || BASE_PER_BIT > 1023) begin : g_chk
    $error("sctc_base_clk: BASE_PER_BIT out of range");
  end

  logic [7:0] halfCnt_ff;
  logic [9:0] bitCnt_ff;
  logic baseClk_ff;
  logic baseEdge_ff;
  logic bitTick_ff;

  wire halfDone = run && (halfCnt_ff == halfDiv);
  wire riseNow = halfDone && !baseClk_ff;
  wire bitDone = riseNow && (bitCnt_ff == 10'(BASE_PER_BIT - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halfCnt_ff <= 8'h00;
      baseClk_ff <= 1'b0;
    end else if (!run) begin
      halfCnt_ff <= 8'h00;
      baseClk_ff <= 1'b0;
    end else begin
      halfCnt_ff <= halfDone ? 8'h00 : halfCnt_ff + 8'h01;
      baseClk_ff <= baseClk_ff ^ halfDone;
    end
  end

  // restart only realigns bit timing; the card clock itself keeps running
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_ff <= 10'h000;
    end else if (!run || restart || bitDone) begin
      bitCnt_ff <= 10'h000;
    end else if (riseNow) begin
      bitCnt_ff <= bitCnt_ff + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baseEdge_ff <= 1'b0;
      bitTick_ff <= 1'b0;
    end else begin
      baseEdge_ff <= halfDone;
      bitTick_ff <= bitDone && !restart;
    end
  end

  assign baseClk = baseClk_ff;
  assign baseEdge = baseEdge_ff;
  assign bitTick = bitTick_ff;

endmodule : sctc_base_clk

// ==== sctc_top.sv ====
/*
  Serial transmitter start-up and card clock pin control, APB slave.
  Assumes an APB master on clk; the transmit pin input is asynchronous.
*/
`timescale 1ns/100ps
`include "sctc_params.svh"

module sctc_top import sctc_pkg::*; #(
  parameter int BASE_PER_BIT = `SCTC_BASE_PER_BIT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txPinIn,
  output logic txPinOut,
  output logic txPinOe,
  output logic sckPinOut,
  output logic sckPinOe
);

  sctc_mode_t mode_ff;
  sctc_ctrl_t ctrl_ff;
  sctc_scm_t scm_ff;
  sctc_state_t state_ff;
  sctc_state_t nxt_state;
  logic [7:0] rate_ff;
  logic [7:0] tdata_ff;
  logic tdFull_ff;
  logic tend_ff;
  logic [11:0] shift_ff;
  logic [3:0] bitIdx_ff;
  logic [1:0] selApplied_ff;
  logic [1:0] nxt_sel;
  logic [1:0] lineSync_ff;
  logic txEnLast_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic txOut_ff;
  logic txOe_ff;
  logic sckOut_ff;
  logic sckOe_ff;
  logic baseClk;
  logic baseEdge;
  logic bitTick;

  // register decode
  wire accPhase = psel && penable;
  wire wrTake = accPhase && pready_ff && pwrite;
  wire hitMode = (paddr == `SCTC_OFS_MODE);
  wire hitCtrl = (paddr == `SCTC_OFS_CTRL);
  wire hitRate = (paddr == `SCTC_OFS_RATE);
  wire hitScm = (paddr == `SCTC_OFS_SCMODE);
  wire hitTdata = (paddr == `SCTC_OFS_TDATA);
  wire hitStat = (paddr == `SCTC_OFS_STAT);
  wire hitAny = hitMode | hitCtrl | hitRate | hitScm | hitTdata | hitStat;
  wire [31:0] statWord = {27'h0000000, lineSync_ff[1], state_ff, tend_ff, !tdFull_ff};
  wire [31:0] rdMux =
    hitMode ? {24'h000000, mode_ff.gsmFlag, mode_ff.chr7, mode_ff.parEn, mode_ff.parOdd,
               mode_ff.stop2, 3'h0} :
    hitCtrl ? {26'h0000000, ctrl_ff.txEn, ctrl_ff.rxEn, 2'h0, ctrl_ff.cke} :
    hitRate ? {24'h000000, rate_ff} :
    hitScm ? {29'h00000000, scm_ff.inv, 1'b0, scm_ff.scEn} :
    hitStat ? statWord : 32'h00000000;

  // frame assembly
  wire scMode = scm_ff.scEn;
  wire gsmActive = scMode && mode_ff.gsmFlag;
  wire seven = mode_ff.chr7 && !scMode;
  wire parUse = scMode || mode_ff.parEn;
  wire [7:0] sendByte = (scMode && scm_ff.inv) ? ~tdata_ff : tdata_ff;
  wire parBit = (seven ? ^sendByte[6:0] : ^sendByte) ^ (mode_ff.parOdd && !scMode);
  wire parSlot = parUse ? parBit : 1'b1;
  wire [11:0] frameWord = seven ? {3'b111, parSlot, sendByte[6:0], 1'b0} :
                                  {2'b11, parSlot, sendByte, 1'b0};
  wire [3:0] frameLen = 4'h1 + (seven ? 4'h7 : 4'h8) + {3'h0, parUse} +
                        (mode_ff.stop2 ? 4'h2 : 4'h1);
  wire [3:0] lastBit = frameLen - 4'h1;
  wire frameEnd = bitTick && (bitIdx_ff == lastBit);
  wire txEnRise = ctrl_ff.txEn && !txEnLast_ff;
  wire loadNow = tdFull_ff && bitTick;

  wire baseRun = ctrl_ff.txEn || ctrl_ff.cke[0] || gsmActive;

  sctc_base_clk #(
    .BASE_PER_BIT(BASE_PER_BIT)
  ) u_base (
    .clk(clk),
    .reset_n(reset_n),
    .run(baseRun),
    .restart(txEnRise),
    .halfDiv(rate_ff),
    .baseClk(baseClk),
    .baseEdge(baseEdge),
    .bitTick(bitTick)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF: begin
        if (ctrl_ff.txEn) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (frameEnd) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (loadNow) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (frameEnd && !tdFull_ff) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    if (!ctrl_ff.txEn) begin
      nxt_state = ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_OFF;
      txEnLast_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      txEnLast_ff <= ctrl_ff.txEn;
    end
  end

  wire startShift = (state_ff == ST_IDLE && loadNow) ||
                    (state_ff == ST_SHIFT && frameEnd && tdFull_ff);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= 12'hFFF;
      bitIdx_ff <= 4'h0;
    end else if (startShift || txEnRise || (state_ff == ST_WAIT && frameEnd)) begin
      shift_ff <= startShift ? frameWord : 12'hFFF;
      bitIdx_ff <= 4'h0;
    end else if (bitTick && state_ff != ST_IDLE) begin
      shift_ff <= {1'b1, shift_ff[11:1]};
      bitIdx_ff <= bitIdx_ff + 4'h1;
    end
  end

  // data write is taken only when the holding register is empty
  wire tdWrite = wrTake && hitTdata && !tdFull_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tdata_ff <= `SCTC_RST_BYTE;
      tdFull_ff <= 1'b0;
      tend_ff <= 1'b1;
    end else begin
      if (tdWrite) begin
        tdata_ff <= pwdata[7:0];
      end
      tdFull_ff <= tdWrite || (tdFull_ff && !startShift);
      tend_ff <= (state_ff != ST_SHIFT && !tdFull_ff && !tdWrite);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= '0;
      ctrl_ff <= '0;
      scm_ff <= '0;
      rate_ff <= `SCTC_RST_RATE;
    end else if (wrTake) begin
      if (hitMode) begin
        mode_ff <= '{gsmFlag: pwdata[`SCTC_POS_GSM], chr7: pwdata[`SCTC_POS_CHR7],
                     parEn: pwdata[`SCTC_POS_PAREN], parOdd: pwdata[`SCTC_POS_PARODD],
                     stop2: pwdata[`SCTC_POS_STOP2]};
      end
      if (hitCtrl) begin
        ctrl_ff <= '{cke: pwdata[`SCTC_POS_CKE +: 2], rxEn: pwdata[`SCTC_POS_RXEN],
                     txEn: pwdata[`SCTC_POS_TXEN]};
      end
      if (hitScm) begin
        scm_ff <= '{inv: pwdata[`SCTC_POS_INV], scEn: pwdata[`SCTC_POS_SCEN]};
      end
      if (hitRate) begin
        rate_ff <= pwdata[7:0];
      end
    end
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= accPhase && !pready_ff;
      pslverr_ff <= accPhase && !pready_ff && !hitAny;
      if (accPhase && !pready_ff && !pwrite) begin
        prdata_ff <= rdMux;
      end
    end
  end

  // line level is asynchronous, two stages before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lineSync_ff <= 2'b11;
    end else begin
      lineSync_ff <= {lineSync_ff[0], txPinIn};
    end
  end

  // in card mode with the gsm flag, a new select is applied only at a half-period boundary
  // without the gsm flag the select acts at once
  assign nxt_sel = (!gsmActive || baseEdge) ? ctrl_ff.cke : selApplied_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selApplied_ff <= 2'b00;
    end else begin
      selApplied_ff <= nxt_sel;
    end
  end

  // transmit pin drive; card mode is open drain
  wire txActive = (state_ff != ST_OFF);
  wire nxtTxOe = scMode ? (state_ff == ST_SHIFT && !shift_ff[0]) : txActive;
  wire nxtTxOut = scMode ? 1'b0 : (state_ff == ST_SHIFT ? shift_ff[0] : 1'b1);
  // clock pin; the pin drives once bit0 is set, and always with the gsm flag in card mode
  wire nxtSckOe = gsmActive ? 1'b1 : selApplied_ff[0];
  wire nxtSckOut = (gsmActive && selApplied_ff == 2'b00) ? 1'b0 :
                   (gsmActive && selApplied_ff == 2'b10) ? 1'b1 : baseClk;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txOe_ff <= 1'b0;
      txOut_ff <= 1'b1;
      sckOe_ff <= 1'b0;
      sckOut_ff <= 1'b0;
    end else begin
      txOe_ff <= nxtTxOe;
      txOut_ff <= nxtTxOut;
      sckOe_ff <= nxtSckOe;
      sckOut_ff <= nxtSckOut;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign txPinOut = txOut_ff;
  assign txPinOe = txOe_ff;
  assign sckPinOut = sckOut_ff;
  assign sckPinOe = sckOe_ff;

  // helper count of bit ticks inside the wait frame, apart from bitIdx
  logic [3:0] waitTicks_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitTicks_ff <= 4'h0;
    end else if (state_ff != ST_WAIT) begin
      waitTicks_ff <= 4'h0;
    end else if (bitTick) begin
      waitTicks_ff <= waitTicks_ff + 4'h1;
    end
  end

  AST_TX_HIZ_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    (!ctrl_ff.txEn && !scMode) ##1 !ctrl_ff.txEn |=> !txPinOe)
    else $error("transmit pin driven while transmit disabled");

  AST_WAIT_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_WAIT && !scMode) |=> (txPinOe && txPinOut))
    else $error("wait frame not driven high");

  AST_SCK_HIZ: assert property (@(posedge clk) disable iff (!reset_n)
    (!gsmActive && !selApplied_ff[0]) |=> !sckPinOe)
    else $error("clock pin driven with select bit0 clear");

  AST_SCK_RUN: assert property (@(posedge clk) disable iff (!reset_n)
    (scMode && !gsmActive && ctrl_ff.cke[0] && !ctrl_ff.txEn && !ctrl_ff.rxEn)
      |=> ##1 (sckPinOe && sckPinOut == $past(baseClk)))
    else $error("card clock stopped while bit0 set");

  AST_SC_WAIT_HIZ: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_WAIT && scMode) |=> !txPinOe)
    else $error("card transmit pin driven during wait frame");

  AST_GSM_NO_RUNT: assert property (@(posedge clk) disable iff (!reset_n)
    (gsmActive && $past(gsmActive) && selApplied_ff != $past(selApplied_ff))
      |-> $past(baseEdge))
    else $error("clock select applied off a half-period boundary");

  AST_GSM_FIX: assert property (@(posedge clk) disable iff (!reset_n)
    (gsmActive && selApplied_ff[0] == 1'b0)
      |=> (sckPinOe && sckPinOut == $past(selApplied_ff[1])))
    else $error("fixed clock level wrong");

  AST_WAIT_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_WAIT && nxt_state == ST_IDLE) |->
      (bitTick && waitTicks_ff == frameLen - 4'h1))
    else $error("wait frame ended early");

  AST_DATA_AFTER_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_SHIFT && $past(state_ff) != ST_SHIFT) |-> $past(state_ff) == ST_IDLE)
    else $error("data sent before wait frame");

endmodule : sctc_top

// ==== sctc_far_end.sv ====
/*
  Far-end receiver on the serial transmit wire, with the wire's pull-up.
  Assumes 8 data bits, lsb first, and a bit time of BIT_CLKS clocks.
*/
`timescale 1ns/100ps

module sctc_far_end #(
  parameter int BIT_CLKS = 4
) (
  input wire logic clk,
  input wire logic txOut,
  input wire logic txOe,
  output logic lineLvl,
  output logic [7:0] rxByte,
  output logic [7:0] rxCount
);
  // a released wire floats up through the pull-up, never holds the old level
  assign lineLvl = txOe ? txOut : 1'h1;

  initial begin
    rxByte = 8'h00;
    rxCount = 8'h00;
    forever begin
      @(negedge lineLvl);
      // sample mid-bit so that edge jitter of one clock does not matter
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (lineLvl == 1'h0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge clk);
          rxByte[i] = lineLvl;
        end
        rxCount = rxCount + 8'h01;
        // step over a parity slot so that a low parity bit is not taken for a start
        repeat (BIT_CLKS) @(posedge clk);
      end
    end
  end
endmodule : sctc_far_end

// ==== test_sctc_top.sv ====
/*
  Self-checking bench of the transmit start-up and card clock block.
  Assumes the far-end model, APB with one wait state, RATE 0 and 2 base clocks a bit.
*/
`timescale 1ns/100ps
`include "sctc_params.svh"

module test_sctc_top;
  import sctc_pkg::*;
  localparam logic [31:0] TXEN_BIT = 32'h1 << `SCTC_POS_TXEN;
  localparam logic [31:0] GSM_BIT = 32'h1 << `SCTC_POS_GSM;
  // clocks a bit: 2 base clocks of 2 clocks each at RATE 0
  localparam int BIT = 4;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic txPinOut, txPinOe, sckPinOut, sckPinOe, lineLvl;
  logic [7:0] rxByte, rxCount;
  int errors, cmp_count;

  sctc_top #(.BASE_PER_BIT(2)) dut_u (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txPinIn(lineLvl), .txPinOut(txPinOut),
    .txPinOe(txPinOe), .sckPinOut(sckPinOut), .sckPinOe(sckPinOe));
  sctc_far_end #(.BIT_CLKS(4)) far_u (.clk(clk), .txOut(txPinOut), .txOe(txPinOe),
    .lineLvl(lineLvl), .rxByte(rxByte), .rxCount(rxCount));

  task automatic stop_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    // ready is looked at where it stands; the transfer ends at the next rising edge
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("MISMATCH %0t apb ready never came", $time);
    end
    q = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask : wr

  task automatic toggles(input int cyc, output int t);
    logic last;
    t = 0;
    @(negedge clk);
    last = sckPinOut;
    repeat (cyc) begin
      @(negedge clk);
      if (sckPinOut !== last) t++;
      last = sckPinOut;
    end
  endtask : toggles

  // waits out the start-up frame, then expects byte b on the wire
  task automatic send_check(input logic [7:0] b, input logic card);
    int n;
    int bad;
    int fr;
    logic [7:0] c0;
    n = 0;
    bad = 0;
    fr = (card ? 11 : 10) * BIT;
    c0 = rxCount;
    fork
      wr(`SCTC_OFS_TDATA, {24'h000000, b});
      while (lineLvl === 1'h1 && n < 200) begin
        @(negedge clk);
        n++;
        // the pin needs a few cycles to leave its released state after the enable
        if (lineLvl === 1'h1 && n > 3 && txPinOe !== !card) bad++;
      end
    join
    // a byte waiting at the frame end starts at the next bit tick
    chk(n >= fr + BIT && n <= fr + BIT + 6, 1'h1, "wait length");
    chk(bad, 0, "pin during wait");
    n = 0;
    while (rxCount == c0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(rxByte, b, "received byte");
  endtask : send_check

  task automatic t_bus;
    logic [31:0] q;
    logic e;
    apb(1'h0, `SCTC_OFS_RATE, 32'h0, q, e);
    chk(q, {24'h000000, `SCTC_RST_RATE}, "rate reset");
    chk({31'h0, e}, 32'h0, "mapped read error");
    apb(1'h0, `SCTC_OFS_STAT, 32'h0, q, e);
    chk(q, (32'h1 << `SCTC_POS_LINE) | (32'h1 << `SCTC_POS_TEND) | (32'h1 << `SCTC_POS_TDE),
        "status reset");
    apb(1'h0, 12'h020, 32'h0, q, e);
    chk(q, 32'h0, "unmapped read data");
    chk({31'h0, e}, 32'h1, "unmapped read error");
  endtask : t_bus

  task automatic t_async;
    chk(txPinOe, 1'h0, "tx float after reset");
    wr(`SCTC_OFS_RATE, 32'h0);
    wr(`SCTC_OFS_MODE, 32'h0);
    wr(`SCTC_OFS_CTRL, TXEN_BIT);
    send_check(8'hA5, 1'h0);
    wr(`SCTC_OFS_CTRL, 32'h0);
    repeat (3) @(negedge clk);
    chk(txPinOe, 1'h0, "tx float after disable");
  endtask : t_async

  task automatic t_card;
    int t;
    wr(`SCTC_OFS_SCMODE, 32'h1);
    repeat (2) @(negedge clk);
    chk({sckPinOe, txPinOe}, 2'h0, "card pins float");
    wr(`SCTC_OFS_CTRL, 32'h1);
    toggles(16, t);
    chk({sckPinOe, 1'(t >= 8)}, 2'h3, "clock started");
    wr(`SCTC_OFS_CTRL, TXEN_BIT | 32'h1);
    send_check(8'h3C, 1'h1);
    wr(`SCTC_OFS_CTRL, 32'h1);
    toggles(16, t);
    chk({sckPinOe, 1'(t >= 8)}, 2'h3, "clock runs, both enables off");
    wr(`SCTC_OFS_CTRL, 32'h0);
  endtask : t_card

  task automatic t_gsm;
    logic [1:0] sel [3] = '{2'h0, 2'h2, 2'h1};
    int t;
    // pin fixed first, then modes, then clock start
    wr(`SCTC_OFS_CTRL, 32'h2);
    wr(`SCTC_OFS_MODE, GSM_BIT);
    wr(`SCTC_OFS_SCMODE, 32'h1);
    for (int i = 0; i < 3; i++) begin
      // select is only changed once the gsm flag is set
      wr(`SCTC_OFS_CTRL, {30'h0, sel[i]});
      repeat (4) @(negedge clk);
      toggles(16, t);
      if (sel[i] == 2'h1) begin
        chk({sckPinOe, 1'(t >= 8)}, 2'h3, "gsm clock output");
      end else begin
        chk({sckPinOe, sckPinOut, 1'(t == 0)}, {1'h1, sel[i][1], 1'h1}, "gsm fixed");
      end
    end
  endtask : t_gsm

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 20000);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    reset_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    t_bus();
    t_async();
    t_card();
    t_gsm();
    stop_test();
  end
endmodule : test_sctc_top
